// ### shared/mdf_pkg.sv
// Constants for the data-move and flag-operation execution unit.
// Assumes a single 40 MHz clock and an AHB-Lite register port.
package mdf_pkg;
  // ---------------------------------------------------------------
  // Opcodes and decode masks
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_ST_ACC_IND = 8'hA0;
  localparam logic [7:0] OP_ST_IMM_IND = 8'hB0;
  localparam logic [7:0] OP_ACC_TO_PSW = 8'hD7;
  localparam logic [7:0] OP_PAGE_READ  = 8'hA3;
  localparam logic [7:0] OP_PAGE3_READ = 8'hE3;
  localparam logic [7:0] OP_EXT_READ   = 8'h80;
  localparam logic [7:0] OP_EXT_WRITE  = 8'h90;
  localparam logic [7:0] OP_SWAP_REG   = 8'h28;
  localparam logic [7:0] OP_SWAP_IND   = 8'h20;
  localparam logic [7:0] OP_NIB_SWAP   = 8'h30;
  localparam logic [7:0] OP_INV_C      = 8'hA7;
  localparam logic [7:0] OP_INV_F0     = 8'h95;
  localparam logic [7:0] OP_INV_F1     = 8'hB5;
  localparam logic [7:0] OP_CLR_C      = 8'h97;
  localparam logic [7:0] OP_CLR_F0     = 8'h85;
  localparam logic [7:0] OP_CLR_F1     = 8'hA5;
  localparam logic [7:0] MASK_IND      = 8'hFE;
  localparam logic [7:0] MASK_REG      = 8'hF8;
  // ---------------------------------------------------------------
  // Status word layout and register banks
  // ---------------------------------------------------------------
  localparam int         PSW_C       = 7;
  localparam int         PSW_AC      = 6;
  localparam int         PSW_F0      = 5;
  localparam int         PSW_BS      = 4;
  localparam logic [7:0] BANK0_BASE  = 8'h00;
  localparam logic [7:0] BANK1_BASE  = 8'h18;
  localparam logic [3:0] PAGE_THREE  = 4'h3;
  localparam logic [7:0] ACC_RESET   = 8'h00;
  localparam logic [7:0] PSW_RESET   = 8'h00;
  // ---------------------------------------------------------------
  // Register map (byte offsets) and bus codes
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CMD     = 8'h00;
  localparam logic [7:0] REG_ACC     = 8'h04;
  localparam logic [7:0] REG_PSW     = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0C;
  localparam logic [7:0] REG_FLAG1   = 8'h10;
  localparam logic [1:0] HTRANS_NSEQ = 2'h2;
  localparam logic       HRESP_OKAY  = 1'h0;
endpackage : mdf_pkg

// ### shared/mdf_reg_if.sv
// Register strobe bundle between the bus slave and the execution unit.
// Assumes one clock domain; write strobe lasts one cycle.
`timescale 1ns/1ps
`default_nettype none
interface mdf_reg_if;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slave (output wr, output addr, output wdata, input rdata);
  modport regs  (input wr, input addr, input wdata, output rdata);
endinterface : mdf_reg_if
`default_nettype wire

// ### shared/mdf_ram_if.sv
// Internal data memory ports: two asynchronous reads, one write.
// Assumes writes land on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
interface mdf_ram_if #(parameter int ADDR_W = 6);
  logic [ADDR_W-1:0] raddr_a;
  logic [7:0]        rdata_a;
  logic [ADDR_W-1:0] raddr_b;
  logic [7:0]        rdata_b;
  logic              we;
  logic [ADDR_W-1:0] waddr;
  logic [7:0]        wdata;
  modport ctrl (output raddr_a, output raddr_b, output we, output waddr, output wdata,
                input rdata_a, input rdata_b);
  modport mem  (input raddr_a, input raddr_b, input we, input waddr, input wdata,
                output rdata_a, output rdata_b);
endinterface : mdf_ram_if
`default_nettype wire

// ### core/mdf_data_ram.sv
// Internal data memory holding the working registers and scratch bytes.
// Assumes synchronous reset; contents are not cleared by reset.
`timescale 1ns/1ps
`default_nettype none
module mdf_data_ram #(
  parameter int ADDR_W = 6
) (
  input  wire logic clk,
  mdf_ram_if.mem    ram
);
  logic [7:0] mem_q [2**ADDR_W];

  assign ram.rdata_a = mem_q[ram.raddr_a];
  assign ram.rdata_b = mem_q[ram.raddr_b];

  always_ff @(posedge clk) begin
    if (ram.we) begin
      mem_q[ram.waddr] <= ram.wdata;
    end
  end
endmodule : mdf_data_ram
`default_nettype wire

// ### core/mdf_ahb_slave.sv
// AHB-Lite slave front end: zero wait states, always OKAY.
// Assumes single word transfers; read data is muxed from the latched address.
`timescale 1ns/1ps
`default_nettype none
module mdf_ahb_slave (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  mdf_reg_if.slave         bus
);
  logic       wr_q;
  logic       wr_d;
  logic [7:0] addr_q;
  logic [7:0] addr_d;

  always_comb begin
    wr_d   = 1'b0;
    addr_d = addr_q;
    if (hsel && hready && htrans == mdf_pkg::HTRANS_NSEQ) begin
      wr_d   = hwrite;
      addr_d = haddr[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q   <= wr_d;
      addr_q <= addr_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = mdf_pkg::HRESP_OKAY;
  assign hrdata    = bus.rdata;
  assign bus.wr    = wr_q;
  assign bus.addr  = addr_q;
  assign bus.wdata = hwdata;
endmodule : mdf_ahb_slave
`default_nettype wire

// ### core/mdf_move_flag_unit.sv
// Execution unit for data moves, exchanges, table reads, external data
// access and carry/user flag operations of an 8-bit microcontroller core.
// Assumes program and external memories answer within the second cycle.
// Behaviour
// - 0xA0/1: store accumulator at @R0/@R1
// - 0xB0/1: store immediate at @R0/@R1, two cycles
// - 0xD7: accumulator copied into status word
// - 0xA3: read current page at accumulator offset
// - 0xE3: read page three at accumulator offset
// - 0x80/1: external read @R into accumulator
// - 0x90/1: external write accumulator to @R
// - 0x28-2F: swap accumulator with working register
// - 0x20/1: swap accumulator with @R byte
// - 0x30/1: swap low nibbles with @R byte
// - 0xA7: invert carry only
// - 0x95/0xB5: invert user flag zero/one
// - 0x97: clear carry
// - 0x85/0xA5: clear user flag zero/one
// - Program addresses 12 bits, immediates 8 bits
// - Unmarked flags keep their values
// - Bank select maps registers to 0-7 or 24-31
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module mdf_move_flag_unit #(
  parameter int ADDR_W = 6,
  parameter int PADDR_W = 12
) (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic               hready,
  input  wire logic [31:0]        hwdata,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  input  wire logic [3:0]         pc_page,
  output logic [PADDR_W-1:0]      prog_addr,
  output logic                    prog_rd,
  input  wire logic [7:0]         prog_data,
  output logic [7:0]              ext_addr,
  output logic [7:0]              ext_wdata,
  output logic                    ext_rd,
  output logic                    ext_wr,
  input  wire logic [7:0]         ext_rdata,
  output logic                    pass_valid,
  output logic [7:0]              pass_opcode
);
  // ---------------------------------------------------------------
  // Types and sub-blocks
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MDF_IDLE  = 3'b001,
    MDF_EXEC1 = 3'b010,
    MDF_EXEC2 = 3'b100
  } mdf_state_t;

  typedef enum logic [4:0] {
    K_NONE, K_ST_ACC, K_ST_IMM, K_PSW, K_PAGE, K_PAGE3, K_XRD, K_XWR,
    K_SWR, K_SWI, K_NIB, K_INVC, K_INVF0, K_INVF1, K_CLRC, K_CLRF0, K_CLRF1
  } mdf_kind_t;

  mdf_reg_if             regs ();
  mdf_ram_if #(.ADDR_W(ADDR_W)) ram ();

  mdf_ahb_slave u_slave (
    .clk       (clk),
    .reset_n   (reset_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .bus       (regs.slave)
  );

  mdf_data_ram #(.ADDR_W(ADDR_W)) u_ram (
    .clk (clk),
    .ram (ram.mem)
  );

  function automatic mdf_kind_t mdf_decode(input logic [7:0] op);
    mdf_kind_t k;
    k = K_NONE;
    if ((op & mdf_pkg::MASK_IND) == mdf_pkg::OP_ST_ACC_IND) k = K_ST_ACC;
    if ((op & mdf_pkg::MASK_IND) == mdf_pkg::OP_ST_IMM_IND) k = K_ST_IMM;
    if ((op & mdf_pkg::MASK_IND) == mdf_pkg::OP_EXT_READ)   k = K_XRD;
    if ((op & mdf_pkg::MASK_IND) == mdf_pkg::OP_EXT_WRITE)  k = K_XWR;
    if ((op & mdf_pkg::MASK_IND) == mdf_pkg::OP_SWAP_IND)   k = K_SWI;
    if ((op & mdf_pkg::MASK_IND) == mdf_pkg::OP_NIB_SWAP)   k = K_NIB;
    if ((op & mdf_pkg::MASK_REG) == mdf_pkg::OP_SWAP_REG)   k = K_SWR;
    if (op == mdf_pkg::OP_ACC_TO_PSW) k = K_PSW;
    if (op == mdf_pkg::OP_PAGE_READ)  k = K_PAGE;
    if (op == mdf_pkg::OP_PAGE3_READ) k = K_PAGE3;
    if (op == mdf_pkg::OP_INV_C)      k = K_INVC;
    if (op == mdf_pkg::OP_INV_F0)     k = K_INVF0;
    if (op == mdf_pkg::OP_INV_F1)     k = K_INVF1;
    if (op == mdf_pkg::OP_CLR_C)      k = K_CLRC;
    if (op == mdf_pkg::OP_CLR_F0)     k = K_CLRF0;
    if (op == mdf_pkg::OP_CLR_F1)     k = K_CLRF1;
    return k;
  endfunction : mdf_decode

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  mdf_state_t          state_q, state_d;
  logic [7:0]          acc_q, acc_d;
  logic [7:0]          psw_q, psw_d;
  logic                flag1_q, flag1_d;
  logic [7:0]          op_q, op_d;
  logic [7:0]          imm_q, imm_d;
  logic [PADDR_W-1:0]  prog_addr_q, prog_addr_d;
  logic                prog_rd_q, prog_rd_d;
  logic [7:0]          ext_addr_q, ext_addr_d;
  logic [7:0]          ext_wdata_q, ext_wdata_d;
  logic                ext_rd_q, ext_rd_d;
  logic                ext_wr_q, ext_wr_d;
  logic                pass_q, pass_d;
  logic [7:0]          pass_op_q, pass_op_d;
  mdf_kind_t           kind;
  logic [7:0]          bank_base;
  logic [7:0]          reg_sel;
  logic                busy;

  assign kind      = mdf_decode(op_q);
  assign busy      = state_q != MDF_IDLE;
  assign bank_base = psw_q[mdf_pkg::PSW_BS] ? mdf_pkg::BANK1_BASE : mdf_pkg::BANK0_BASE;
  // Indirect forms name only R0/R1, so the mask keeps bit 0 only
  assign reg_sel   = (kind == K_SWR) ? {5'h00, op_q[2:0]} : {7'h00, op_q[0]};
  assign ram.raddr_a = ADDR_W'(bank_base + reg_sel);
  assign ram.raddr_b = ram.rdata_a[ADDR_W-1:0];

  // ---------------------------------------------------------------
  // Register file read mux
  // ---------------------------------------------------------------
  always_comb begin
    case (regs.addr)
      mdf_pkg::REG_CMD:    regs.rdata = {16'h0000, imm_q, op_q};
      mdf_pkg::REG_ACC:    regs.rdata = {24'h000000, acc_q};
      mdf_pkg::REG_PSW:    regs.rdata = {24'h000000, psw_q};
      mdf_pkg::REG_STATUS: regs.rdata = {16'h0000, pass_op_q, 6'h00, pass_q, busy};
      mdf_pkg::REG_FLAG1:  regs.rdata = {31'h00000000, flag1_q};
      default:             regs.rdata = 32'h00000000;
    endcase
  end

  // ---------------------------------------------------------------
  // Next-state and execution
  // ---------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    acc_d       = acc_q;
    psw_d       = psw_q;
    flag1_d     = flag1_q;
    op_d        = op_q;
    imm_d       = imm_q;
    prog_addr_d = prog_addr_q;
    prog_rd_d   = 1'b0;
    ext_addr_d  = ext_addr_q;
    ext_wdata_d = ext_wdata_q;
    ext_rd_d    = 1'b0;
    ext_wr_d    = 1'b0;
    pass_d      = 1'b0;
    pass_op_d   = pass_op_q;
    ram.we      = 1'b0;
    ram.waddr   = ram.raddr_b;
    ram.wdata   = acc_q;
    case (state_q)
      MDF_IDLE: begin
        // Software writes are dropped while an instruction is in flight
        if (regs.wr && regs.addr == mdf_pkg::REG_CMD) begin
          op_d    = regs.wdata[7:0];
          imm_d   = regs.wdata[15:8];
          state_d = MDF_EXEC1;
        end else if (regs.wr && regs.addr == mdf_pkg::REG_ACC) begin
          acc_d = regs.wdata[7:0];
        end else if (regs.wr && regs.addr == mdf_pkg::REG_PSW) begin
          psw_d = regs.wdata[7:0];
        end else if (regs.wr && regs.addr == mdf_pkg::REG_FLAG1) begin
          flag1_d = regs.wdata[0];
        end
      end
      MDF_EXEC1: begin
        state_d = MDF_IDLE;
        case (kind)
          K_ST_ACC: ram.we = 1'b1;
          K_ST_IMM: state_d = MDF_EXEC2;
          K_PSW:    psw_d = acc_q;
          K_PAGE: begin
            prog_addr_d = {pc_page, acc_q};
            prog_rd_d   = 1'b1;
            state_d     = MDF_EXEC2;
          end
          K_PAGE3: begin
            prog_addr_d = {mdf_pkg::PAGE_THREE, acc_q};
            prog_rd_d   = 1'b1;
            state_d     = MDF_EXEC2;
          end
          K_XRD: begin
            ext_addr_d = ram.rdata_a;
            ext_rd_d   = 1'b1;
            state_d    = MDF_EXEC2;
          end
          K_XWR: begin
            ext_addr_d  = ram.rdata_a;
            ext_wdata_d = acc_q;
            ext_wr_d    = 1'b1;
            state_d     = MDF_EXEC2;
          end
          K_SWR: begin
            ram.we    = 1'b1;
            ram.waddr = ram.raddr_a;
            acc_d     = ram.rdata_a;
          end
          K_SWI: begin
            ram.we = 1'b1;
            acc_d  = ram.rdata_b;
          end
          K_NIB: begin
            ram.we    = 1'b1;
            ram.wdata = {ram.rdata_b[7:4], acc_q[3:0]};
            acc_d     = {acc_q[7:4], ram.rdata_b[3:0]};
          end
          K_INVC:  psw_d[mdf_pkg::PSW_C]  = ~psw_q[mdf_pkg::PSW_C];
          K_INVF0: psw_d[mdf_pkg::PSW_F0] = ~psw_q[mdf_pkg::PSW_F0];
          K_INVF1: flag1_d = ~flag1_q;
          K_CLRC:  psw_d[mdf_pkg::PSW_C]  = 1'b0;
          K_CLRF0: psw_d[mdf_pkg::PSW_F0] = 1'b0;
          K_CLRF1: flag1_d = 1'b0;
          default: begin
            pass_d    = 1'b1;
            pass_op_d = op_q;
          end
        endcase
      end
      MDF_EXEC2: begin
        state_d = MDF_IDLE;
        case (kind)
          K_ST_IMM: begin
            ram.we    = 1'b1;
            ram.wdata = imm_q;
          end
          K_PAGE, K_PAGE3: acc_d = prog_data;
          K_XRD:   acc_d = ext_rdata;
          default: acc_d = acc_q;
        endcase
      end
      default: state_d = MDF_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q     <= MDF_IDLE;
      acc_q       <= mdf_pkg::ACC_RESET;
      psw_q       <= mdf_pkg::PSW_RESET;
      flag1_q     <= 1'b0;
      op_q        <= 8'h00;
      imm_q       <= 8'h00;
      prog_addr_q <= '0;
      prog_rd_q   <= 1'b0;
      ext_addr_q  <= 8'h00;
      ext_wdata_q <= 8'h00;
      ext_rd_q    <= 1'b0;
      ext_wr_q    <= 1'b0;
      pass_q      <= 1'b0;
      pass_op_q   <= 8'h00;
    end else begin
      state_q     <= state_d;
      acc_q       <= acc_d;
      psw_q       <= psw_d;
      flag1_q     <= flag1_d;
      op_q        <= op_d;
      imm_q       <= imm_d;
      prog_addr_q <= prog_addr_d;
      prog_rd_q   <= prog_rd_d;
      ext_addr_q  <= ext_addr_d;
      ext_wdata_q <= ext_wdata_d;
      ext_rd_q    <= ext_rd_d;
      ext_wr_q    <= ext_wr_d;
      pass_q      <= pass_d;
      pass_op_q   <= pass_op_d;
    end
  end

  assign prog_addr   = prog_addr_q;
  assign prog_rd     = prog_rd_q;
  assign ext_addr    = ext_addr_q;
  assign ext_wdata   = ext_wdata_q;
  assign ext_rd      = ext_rd_q;
  assign ext_wr      = ext_wr_q;
  assign pass_valid  = pass_q;
  assign pass_opcode = pass_op_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking mdf_cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic e1, e2;
  assign e1 = state_q == MDF_EXEC1;
  assign e2 = state_q == MDF_EXEC2;

  a_st_acc_write: assert property (e1 && kind == K_ST_ACC |->
    ram.we && ram.waddr == ram.rdata_a[ADDR_W-1:0] && ram.wdata == acc_q)
    else $error("accumulator store to memory missing");
  a_imm_store_late: assert property (e1 && kind == K_ST_IMM |->
    !ram.we ##1 (e2 && ram.we && ram.wdata == imm_q) ##1 !busy)
    else $error("immediate store not in second cycle");
  a_psw_load: assert property (e1 && kind == K_PSW |=>
    psw_q == $past(acc_q) && !busy)
    else $error("status word not loaded from accumulator");
  a_page_read: assert property (e1 && kind == K_PAGE |=>
    prog_rd && prog_addr == {$past(pc_page), $past(acc_q)} ##1 acc_q == $past(prog_data))
    else $error("current page table read wrong");
  a_page3_read: assert property (e1 && kind == K_PAGE3 |=>
    prog_rd && prog_addr == {mdf_pkg::PAGE_THREE, $past(acc_q)} ##1 acc_q == $past(prog_data))
    else $error("page three table read wrong");
  a_ext_read: assert property (e1 && kind == K_XRD |=>
    ext_rd && !ext_wr ##1 !ext_rd && acc_q == $past(ext_rdata))
    else $error("external read sequence wrong");
  a_ext_write: assert property (e1 && kind == K_XWR |=>
    ext_wr && ext_wdata == $past(acc_q) && ext_addr == $past(ram.rdata_a) ##1 !ext_wr)
    else $error("external write sequence wrong");
  a_swap_reg: assert property (e1 && kind == K_SWR |=>
    acc_q == $past(ram.rdata_a) && psw_q == $past(psw_q))
    else $error("register swap wrong");
  a_nib_swap: assert property (e1 && kind == K_NIB |=>
    acc_q[7:4] == $past(acc_q[7:4]) && acc_q[3:0] == $past(ram.rdata_b[3:0]))
    else $error("nibble swap wrong");
  a_carry_only: assert property (e1 && kind == K_INVC |=>
    psw_q == ($past(psw_q) ^ 8'h80) && $stable(flag1_q))
    else $error("carry invert touched other flags");
  a_flag_clear: assert property (e1 && (kind == K_CLRC || kind == K_CLRF1) |=>
    ($past(kind) == K_CLRC) ? (!psw_q[mdf_pkg::PSW_C] && $stable(flag1_q))
                            : (!flag1_q && $stable(psw_q)))
    else $error("flag clear failed");
  a_bank_map: assert property (psw_q[mdf_pkg::PSW_BS] && kind == K_SWR |->
    ram.raddr_a == ADDR_W'(8'h18 + {5'h00, op_q[2:0]}))
    else $error("bank one mapping wrong");
  a_pass_other: assert property (e1 && kind == K_NONE |=>
    pass_valid && $stable(acc_q) && $stable(psw_q) && !$past(ram.we))
    else $error("unknown opcode not passed on cleanly");

  c_ext_read:  cover property (e1 && kind == K_XRD ##2 !busy);
  c_nib_swap:  cover property (e1 && kind == K_NIB);
  c_pass_on:   cover property (pass_valid);
  c_bank_one:  cover property (e1 && kind == K_SWR && psw_q[mdf_pkg::PSW_BS]);
endmodule : mdf_move_flag_unit
`default_nettype wire

// ### dv/mdf_mem_model.sv
// Program table and external data memory seen by the move unit.
// Assumes both answer within the strobe cycle, as the unit expects.
`timescale 1ns/1ps
`default_nettype none
module mdf_mem_model (
  input  wire logic        clk,
  input  wire logic [11:0] prog_addr,
  input  wire logic        prog_rd,
  output logic [7:0]       prog_data,
  input  wire logic [7:0]  ext_addr,
  input  wire logic [7:0]  ext_wdata,
  input  wire logic        ext_rd,
  input  wire logic        ext_wr,
  output logic [7:0]       ext_rdata
);
  logic [7:0] mem [256];
  logic [7:0] junk_q = 8'h5A;
  // Undriven buses carry a moving pattern so stale data never passes
  always @(posedge clk) begin
    junk_q <= junk_q + 8'h3B;
    if (ext_wr) mem[ext_addr] <= ext_wdata;
  end
  assign prog_data = prog_rd ? prog_addr[7:0] + {prog_addr[11:8], 4'h5} : junk_q;
  assign ext_rdata = ext_rd ? mem[ext_addr] : ~junk_q;
endmodule : mdf_mem_model
`default_nettype wire

// ### dv/mcu_data_move_flag_ops_test.sv
// Self-checking bench for the move and flag unit, driven over AHB-Lite.
// Assumes the memory model on the far side.
`timescale 1ns/1ps
`default_nettype none
module mcu_data_move_flag_ops_test;
  localparam logic [7:0]  RA = mdf_pkg::REG_ACC;
  localparam logic [7:0]  RP = mdf_pkg::REG_PSW;
  localparam logic [7:0]  RF = mdf_pkg::REG_FLAG1;
  localparam logic [7:0]  FOP [6] = '{8'hA7, 8'h95, 8'hB5, 8'h97, 8'h85, 8'hA5};
  // Keep mask, then flip mask, over {user_flag_one, status word}
  localparam logic [17:0] FMSK [6] = '{{9'h1FF, 9'h080}, {9'h1FF, 9'h020}, {9'h1FF, 9'h100},
                                      {9'h17F, 9'h000}, {9'h1DF, 9'h000}, {9'h0FF, 9'h000}};
  logic        clk, reset_n, hwrite, hready, hreadyout, hresp, cflag, dph, dc;
  logic        prog_rd, ext_rd, ext_wr, pass_valid;
  logic        hsel = 1'b1;
  logic [2:0]  hsize = 3'h2;
  logic [1:0]  htrans;
  logic [3:0]  pc_page;
  logic [7:0]  ext_addr, ext_wdata, ext_rdata, prog_data, pass_opcode, a, b, v;
  logic [8:0]  w;
  logic [11:0] prog_addr;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [31:0] rs = 32'h0000_0048;
  logic [23:0] e;
  logic [23:0] exp_q[$];
  logic [7:0]  pq[$];
  logic [7:0]  rv [16];
  int          mismatches, cmp_count, cyc;
  assign hready = hreadyout;
  mdf_move_flag_unit mdf_move_flag_unit_i (.*);
  mdf_mem_model mdf_mem_model_i (.*);
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction : rnd
  function automatic logic [7:0] pb(input logic [11:0] p);
    return p[7:0] + {p[11:8], 4'h5};
  endfunction : pb
  task automatic cmp(input logic [7:0] id, input logic [31:0] seen, input logic [31:0] ex);
    cmp_count++;
    if (seen !== ex) begin
      mismatches++;
      $display("[ERR] reg_%h expected %h seen %h", id, ex, seen);
    end
  endtask : cmp
  task automatic close_out();
    cmp(8'hFD, 32'(pq.size()), 32'h0);
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  // Address and data phases are each held until hready is seen high
  task automatic xfer(input logic [7:0] ad, input logic wn, input logic [31:0] d, input logic c);
    haddr  <= {24'h000000, ad};
    hwrite <= wn;
    htrans <= mdf_pkg::HTRANS_NSEQ;
    cflag  <= c;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    xfer(ad, 1'b1, {24'h000000, d}, 1'b0);
  endtask : wr
  task automatic chk(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] ex);
    exp_q.push_back({ad, m, ex & m});
    xfer(ad, 1'b0, 32'h0, 1'b1);
  endtask : chk
  // Polls busy so no command is dropped by a write during execution
  task automatic cmd(input logic [7:0] op, input logic [7:0] im);
    int n;
    n = 0;
    xfer(mdf_pkg::REG_CMD, 1'b1, {16'h0000, im, op}, 1'b0);
    do begin
      xfer(mdf_pkg::REG_STATUS, 1'b0, 32'h0, 1'b0);
      n++;
    end while (q[0] !== 1'b0 && n < 9);
    if (n == 9) cmp(8'h0C, {31'h0, q[0]}, 32'h0);
  endtask : cmd
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dph && dc && hready) begin
      e = exp_q.pop_front();
      cmp(e[23:16], {24'h0, hrdata[7:0] & e[15:8]}, {24'h0, e[7:0]});
    end
    if (pass_valid) cmp(8'hFE, {24'h0, pass_opcode}, {24'h0, pq.pop_front()});
    if (dph) cmp(8'hFC, {31'h0, hresp}, {31'h0, mdf_pkg::HRESP_OKAY});
    dph <= reset_n && htrans == mdf_pkg::HTRANS_NSEQ && hready;
    dc  <= cflag;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {reset_n, htrans, haddr, hwrite, hwdata, cflag, pc_page} = '0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(RA, 8'hFF, 8'h00);
    chk(RP, 8'hFF, 8'h00);
    chk(RF, 8'h01, 8'h00);
    wr(8'h20, rnd());
    chk(8'h20, 8'hFF, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      v = rnd();
      b = rnd();
      w = {b[0], v};
      wr(RP, w[7:0]);
      wr(RF, {7'h00, w[8]});
      cmd(FOP[k], 8'h00);
      w = (w & FMSK[k][17:9]) ^ FMSK[k][8:0];
      chk(RP, 8'hFF, w[7:0]);
      chk(RF, 8'h01, {7'h00, w[8]});
    end
    a = rnd();
    wr(RA, a);
    cmd(8'hD7, 8'h00);
    chk(RP, 8'hFF, a);
    chk(RA, 8'hFF, a);
    $display("test flags done");
    for (int k = 0; k < 32; k++) begin
      if (k < 16) rv[k] = rnd();
      wr(RP, {3'h0, k[3], 4'h0});
      wr(RA, (k < 16) ? rv[k[3:0]] : 8'h00);
      cmd({5'h05, k[2:0]}, 8'h00);
      if (k >= 16) chk(RA, 8'hFF, rv[k[3:0]]);
    end
    wr(RP, 8'h00);
    wr(RA, 8'h18);
    cmd(8'h28, 8'h00);
    a = rnd();
    wr(RA, a);
    cmd(8'hA0, 8'h00);
    wr(RP, 8'h10);
    cmd(8'h28, 8'h00);
    chk(RA, 8'hFF, a);
    wr(RP, 8'h00);
    wr(RA, 8'h20);
    cmd(8'h29, 8'h00);
    b = rnd();
    cmd(8'hB1, b);
    a = rnd();
    wr(RA, a);
    cmd(8'h21, 8'h00);
    chk(RA, 8'hFF, b);
    v = rnd();
    wr(RA, v);
    cmd(8'h31, 8'h00);
    chk(RA, 8'hFF, {v[7:4], a[3:0]});
    cmd(8'h21, 8'h00);
    chk(RA, 8'hFF, {a[7:4], v[3:0]});
    $display("test internal moves done");
    for (int k = 0; k < 6; k++) begin
      wr(RA, rnd());
      cmd({7'h14, k[0]}, 8'h00);
      a = rnd();
      wr(RA, a);
      cmd({7'h48, k[0]}, 8'h00);
      wr(RA, 8'h00);
      cmd({7'h40, k[0]}, 8'h00);
      chk(RA, 8'hFF, a);
      pc_page <= a[7:4];
      wr(RA, a);
      cmd(8'hA3, 8'h00);
      chk(RA, 8'hFF, pb({a[7:4], a}));
      wr(RA, a);
      cmd(8'hE3, 8'h00);
      chk(RA, 8'hFF, pb({mdf_pkg::PAGE_THREE, a}));
    end
    $display("test external and table done");
    a = rnd();
    wr(RA, a);
    pq.push_back(8'hF0);
    cmd(8'hF0, 8'h00);
    chk(RA, 8'hFF, a);
    $display("test pass-on done");
    close_out();
  end
endmodule : mcu_data_move_flag_ops_test
`default_nettype wire
